// ---- crff_top.sv ----
// receive shadow buffer, five-entry receive queue and register port
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - five buffer queue behind one window
// - each buffer fifteen bytes incl. stamp
// - shadow hidden, only head readable
// - full flag shows head holds frame
// - shadow filled while filter evaluates
// - accepted frame queued, flag, interrupt
// - back to back frames not lost
// - rejected or bad frames not queued
// - own frames captured, not queued/acked
// - loopback treats own frames as received
// - lost arbitration means normal reception
// - full queue drops frame, flags overrun
// - resume accepting once buffer frees
// - value registers give identifier pattern
// - hit index reports lowest match
// - 32-bit mode: two filters
// - 16-bit mode: four filters
// - 8-bit mode: eight filters
// - closed mode accepts nothing
// - mask zero compares, one ignores
// - any matching filter accepts
// - filter setup changes only in init
module crff_top #(
  parameter int DEPTH = crff_pkg::RX_DEPTH,
  parameter int BYTES = crff_pkg::BUF_BYTES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [crff_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [crff_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [crff_pkg::DATA_W-1:0] reg_rdata_out,
  // frame stream from the bit engine
  input wire logic frame_byte_valid_in,
  input wire logic [crff_pkg::IDX_W-1:0] frame_byte_idx_in,
  input wire logic [crff_pkg::DATA_W-1:0] frame_byte_in,
  input wire logic frame_end_in,
  input wire logic frame_ok_in,
  input wire logic frame_own_in,
  input wire logic [crff_pkg::TS_W-1:0] time_stamp_in,
  // status
  output logic ack_enable_out,
  output logic rx_full_out,
  output logic rx_irq_out,
  output logic overrun_irq_out
);
  import crff_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

  function automatic logic in_block(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                    input int n);
    in_block = (int'(a) >= int'(base)) && (int'(a) < int'(base) + n);
  endfunction

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  crff_filt_if fif ();

  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] irqen_q;
  crff_mode_t mode_q;
  logic [DATA_W-1:0] val_q [FILT_REGS];
  logic [DATA_W-1:0] msk_q [FILT_REGS];
  logic [DATA_W-1:0] shadow_q [BYTES];
  logic [DATA_W-1:0] fifo_q [DEPTH][BYTES];
  logic [HIT_W-1:0] hit_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic overrun_q;
  logic overrun_d;
  logic rx_full_q;
  logic rx_irq_q;
  logic ovr_irq_q;
  logic ack_en_q;
  logic [DATA_W-1:0] rdata_q;
  logic init_mode;
  logic loopback;
  logic accept;
  logic push;
  logic pop;
  logic ovr_set;
  logic ovr_clr;

  assign init_mode = ctrl_q[CTRL_INIT_BIT];
  assign loopback = ctrl_q[CTRL_LOOP_BIT];

  // control registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RST;
      irqen_q <= IRQEN_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == OFF_CTRL) begin
        ctrl_q <= reg_wdata_in;
      end
      if (reg_addr_in == OFF_IRQEN) begin
        irqen_q <= reg_wdata_in;
      end
    end
  end

  // filter setup, locked while on the bus
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mode_q <= CRFF_MODE_32;
      for (int i = 0; i < FILT_REGS; i++) begin
        val_q[i] <= FILT_RST;
        msk_q[i] <= FILT_RST;
      end
    end else if (reg_wr_in && init_mode) begin
      if (reg_addr_in == OFF_ACC_CTRL) begin
        mode_q <= crff_mode_t'(reg_wdata_in[ACC_MODE_LSB +: MODE_W]);
      end
      if (in_block(reg_addr_in, OFF_VAL_BASE, FILT_REGS)) begin
        val_q[FILT_IDX_W'(reg_addr_in - OFF_VAL_BASE)] <= reg_wdata_in;
      end
      if (in_block(reg_addr_in, OFF_MSK_BASE, FILT_REGS)) begin
        msk_q[FILT_IDX_W'(reg_addr_in - OFF_MSK_BASE)] <= reg_wdata_in;
      end
    end
  end

  // filter looks at the identifier bytes as they land in the shadow
  always_comb begin
    for (int b = 0; b < ID_BYTES; b++) begin
      fif.id_byte[b] = shadow_q[b];
    end
    for (int i = 0; i < FILT_REGS; i++) begin
      fif.acc_val[i] = val_q[i];
      fif.acc_msk[i] = msk_q[i];
    end
    fif.mode = mode_q;
  end

  crff_filter u_filter (
    .f (fif.filt)
  );

  // shadow buffer, overwritten by each frame; own frames land here too
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int b = 0; b < BYTES; b++) begin
        shadow_q[b] <= BYTE_ZERO;
      end
    end else if (frame_byte_valid_in && int'(frame_byte_idx_in) < BYTES) begin
      shadow_q[frame_byte_idx_in] <= frame_byte_in;
    end
  end

  // own frames count only in loopback or after lost arbitration
  assign accept = frame_end_in && frame_ok_in && fif.hit &&
                  (!frame_own_in || loopback);
  assign push = accept && (count_q != CNT_FULL);
  assign ovr_set = accept && (count_q == CNT_FULL);
  assign pop = reg_wr_in && (reg_addr_in == OFF_FLAG) &&
               reg_wdata_in[FLAG_RXF_BIT] && (count_q != CNT_ZERO);
  assign ovr_clr = reg_wr_in && (reg_addr_in == OFF_FLAG) && reg_wdata_in[FLAG_OVR_BIT];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + CNT_ONE;
    end else if (pop && !push) begin
      count_d = count_q - CNT_ONE;
    end
    overrun_d = ovr_set ? 1'b1 : (ovr_clr ? 1'b0 : overrun_q);
  end

  // shadow copied into the queue at frame end, stamp inserted on the way
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int e = 0; e < DEPTH; e++) begin
        hit_q[e] <= '0;
        for (int b = 0; b < BYTES; b++) begin
          fifo_q[e][b] <= BYTE_ZERO;
        end
      end
    end else if (push) begin
      hit_q[wr_ptr_q] <= fif.hit_idx;
      for (int b = 0; b < BYTES; b++) begin
        fifo_q[wr_ptr_q][b] <= shadow_q[b];
      end
      if (ctrl_q[CTRL_TS_BIT]) begin
        fifo_q[wr_ptr_q][TS_HI_IDX] <= time_stamp_in[TS_W-1 -: DATA_W];
        fifo_q[wr_ptr_q][TS_LO_IDX] <= time_stamp_in[DATA_W-1:0];
      end
    end
  end

  // pointers and fill count; a push beside a pop keeps the flag set
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= CNT_ZERO;
    end else begin
      if (push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      count_q <= count_d;
    end
  end

  // flags, interrupt levels and acknowledge permission
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      overrun_q <= 1'b0;
      rx_full_q <= 1'b0;
      rx_irq_q <= 1'b0;
      ovr_irq_q <= 1'b0;
      ack_en_q <= 1'b1;
    end else begin
      overrun_q <= overrun_d;
      rx_full_q <= (count_d != CNT_ZERO);
      rx_irq_q <= (count_d != CNT_ZERO) && irqen_q[IRQ_RX_BIT];
      ovr_irq_q <= overrun_d && irqen_q[IRQ_OVR_BIT];
      ack_en_q <= !frame_own_in || loopback;
    end
  end

  // read data valid only in the cycle after the strobe; only head is visible
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_q <= BYTE_ZERO;
    end else begin
      rdata_q <= BYTE_ZERO;
      if (reg_rd_in) begin
        if (reg_addr_in == OFF_CTRL) begin
          rdata_q <= ctrl_q;
        end else if (reg_addr_in == OFF_FLAG) begin
          rdata_q[FLAG_RXF_BIT] <= rx_full_q;
          rdata_q[FLAG_OVR_BIT] <= overrun_q;
        end else if (reg_addr_in == OFF_IRQEN) begin
          rdata_q <= irqen_q;
        end else if (reg_addr_in == OFF_ACC_CTRL) begin
          rdata_q[ACC_MODE_LSB +: MODE_W] <= mode_q;
          rdata_q[ACC_HIT_LSB +: HIT_W] <= hit_q[rd_ptr_q];
        end else if (in_block(reg_addr_in, OFF_VAL_BASE, FILT_REGS)) begin
          rdata_q <= val_q[FILT_IDX_W'(reg_addr_in - OFF_VAL_BASE)];
        end else if (in_block(reg_addr_in, OFF_MSK_BASE, FILT_REGS)) begin
          rdata_q <= msk_q[FILT_IDX_W'(reg_addr_in - OFF_MSK_BASE)];
        end else if (in_block(reg_addr_in, OFF_HEAD_BASE, BYTES) && rx_full_q) begin
          rdata_q <= fifo_q[rd_ptr_q][IDX_W'(reg_addr_in - OFF_HEAD_BASE)];
        end
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign rx_full_out = rx_full_q;
  assign rx_irq_out = rx_irq_q;
  assign overrun_irq_out = ovr_irq_q;
  assign ack_enable_out = ack_en_q;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_accept_room;
    accept && (count_q != CNT_FULL);
  endsequence

  sequence s_accept_full;
    accept && (count_q == CNT_FULL);
  endsequence

  property p_depth;
    count_q <= CNT_FULL;
  endproperty
  a_depth: assert property (p_depth) else $error("queue count above depth");

  property p_queue_flag;
    s_accept_room |=> rx_full_out && (count_q != CNT_ZERO);
  endproperty
  a_queue_flag: assert property (p_queue_flag) else $error("accepted frame not queued");

  property p_last_pop;
    (count_q == CNT_ONE) && pop && !push |=> !rx_full_out ##1 (rx_full_out == $past(push));
  endproperty
  a_last_pop: assert property (p_last_pop) else $error("full flag stuck after release");

  property p_overrun;
    s_accept_full |=> overrun_q && (count_q == $past(count_q) - CNT_W'($past(pop)));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_reject;
    frame_end_in && !frame_ok_in && !pop |=> $stable(count_q);
  endproperty
  a_reject: assert property (p_reject) else $error("bad frame entered queue");

  property p_own;
    frame_end_in && frame_own_in && !loopback && !pop |=> $stable(count_q) && !ack_enable_out;
  endproperty
  a_own: assert property (p_own) else $error("own frame queued or acked");

  property p_loop;
    frame_end_in && frame_ok_in && frame_own_in && loopback && fif.hit && !count_q[CNT_W-1] |=>
      rx_full_out;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback frame dropped");

  property p_closed;
    mode_q == CRFF_MODE_CLOSED |-> !fif.hit;
  endproperty
  a_closed: assert property (p_closed) else $error("closed filter accepted");

  property p_lock;
    !init_mode && reg_wr_in && in_block(reg_addr_in, OFF_VAL_BASE, FILT_REGS) |=>
      $stable(val_q[0]) && $stable(val_q[FILT_REGS-1]) && $stable(mode_q);
  endproperty
  a_lock: assert property (p_lock) else $error("filter setup changed on bus");

  property p_hit8;
    mode_q == CRFF_MODE_8 && fif.hit |-> ((shadow_q[0] ^ val_q[fif.hit_idx]) &
      ~msk_q[fif.hit_idx]) == BYTE_ZERO;
  endproperty
  a_hit8: assert property (p_hit8) else $error("reported filter does not match");
endmodule
`default_nettype wire

// ---- crff_pkg.sv ----
// constants and types shared by the receive queue and acceptance filter
`default_nettype none
package crff_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int RX_DEPTH = 5;
  localparam int BUF_BYTES = 15;
  localparam int IDX_W = 4;
  localparam int ID_BYTES = 4;
  localparam int FILT_REGS = 8;
  localparam int FILT_IDX_W = 3;
  localparam int HIT_W = 3;
  localparam int TS_W = 16;
  localparam int TS_HI_IDX = 13;
  localparam int TS_LO_IDX = 14;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAG = 6'h01;
  localparam logic [ADDR_W-1:0] OFF_IRQEN = 6'h02;
  localparam logic [ADDR_W-1:0] OFF_ACC_CTRL = 6'h03;
  localparam logic [ADDR_W-1:0] OFF_VAL_BASE = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_MSK_BASE = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_HEAD_BASE = 6'h20;

  // field positions
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_LOOP_BIT = 1;
  localparam int CTRL_TS_BIT = 2;
  localparam int FLAG_RXF_BIT = 0;
  localparam int FLAG_OVR_BIT = 1;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int ACC_HIT_LSB = 0;
  localparam int ACC_MODE_LSB = 4;
  localparam int MODE_W = 2;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h01;
  localparam logic [DATA_W-1:0] IRQEN_RST = 8'h00;
  localparam logic [DATA_W-1:0] FILT_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [MODE_W-1:0] {
    CRFF_MODE_32,
    CRFF_MODE_16,
    CRFF_MODE_8,
    CRFF_MODE_CLOSED
  } crff_mode_t;
endpackage
`default_nettype wire

// ---- crff_filt_if.sv ----
// carrier between the receive core and the acceptance filter
`timescale 1ns/10ps
`default_nettype none
interface crff_filt_if;
  import crff_pkg::*;
  logic [DATA_W-1:0] id_byte [ID_BYTES];
  logic [DATA_W-1:0] acc_val [FILT_REGS];
  logic [DATA_W-1:0] acc_msk [FILT_REGS];
  crff_mode_t mode;
  logic hit;
  logic [HIT_W-1:0] hit_idx;
  modport filt (input id_byte, input acc_val, input acc_msk, input mode,
                output hit, output hit_idx);
  modport core (output id_byte, output acc_val, output acc_msk, output mode,
                input hit, input hit_idx);
endinterface
`default_nettype wire

// ---- crff_filter.sv ----
// acceptance filter: mode dependent bank split and lowest-hit encoder
`timescale 1ns/10ps
`default_nettype none
module crff_filter (
  crff_filt_if.filt f
);
  import crff_pkg::*;

  // a mask bit of one removes that bit from the compare
  function automatic logic byte_ok(input logic [DATA_W-1:0] id, input logic [DATA_W-1:0] val,
                                   input logic [DATA_W-1:0] msk);
    byte_ok = ((id ^ val) & ~msk) == BYTE_ZERO;
  endfunction

  logic [FILT_REGS-1:0] match;

  always_comb begin
    match = '0;
    case (f.mode)
      CRFF_MODE_32: begin
        for (int k = 0; k < 2; k++) begin
          match[k] = 1'b1;
          for (int b = 0; b < ID_BYTES; b++) begin
            match[k] = match[k] & byte_ok(f.id_byte[b], f.acc_val[k*ID_BYTES+b],
                                          f.acc_msk[k*ID_BYTES+b]);
          end
        end
      end
      CRFF_MODE_16: begin
        for (int k = 0; k < 4; k++) begin
          match[k] = byte_ok(f.id_byte[0], f.acc_val[2*k], f.acc_msk[2*k]) &
                     byte_ok(f.id_byte[1], f.acc_val[2*k+1], f.acc_msk[2*k+1]);
        end
      end
      CRFF_MODE_8: begin
        for (int k = 0; k < FILT_REGS; k++) begin
          match[k] = byte_ok(f.id_byte[0], f.acc_val[k], f.acc_msk[k]);
        end
      end
      CRFF_MODE_CLOSED: begin
        match = '0;
      end
      default: begin
        match = '0;
      end
    endcase
  end

  // any match accepts; lowest numbered filter is reported
  always_comb begin
    f.hit = |match;
    f.hit_idx = '0;
    for (int k = FILT_REGS - 1; k >= 0; k--) begin
      if (match[k]) begin
        f.hit_idx = HIT_W'(k);
      end
    end
  end
endmodule
`default_nettype wire

// ---- crff_frame_src.sv ----
// frame stream source standing in for the bit engine
`timescale 1ns/10ps
`default_nettype none
module crff_frame_src (
  // clock
  input wire logic clk_sys_in,
  // frame stream
  output logic frame_byte_valid_out,
  output logic [crff_pkg::IDX_W-1:0] frame_byte_idx_out,
  output logic [crff_pkg::DATA_W-1:0] frame_byte_out,
  output logic frame_end_out,
  output logic frame_ok_out,
  output logic frame_own_out,
  output logic [crff_pkg::TS_W-1:0] time_stamp_out
);
  import crff_pkg::*;
  initial begin
    frame_byte_valid_out = 1'b0;
    frame_byte_idx_out = 4'h0;
    frame_byte_out = 8'h00;
    frame_end_out = 1'b0;
    frame_ok_out = 1'b0;
    frame_own_out = 1'b0;
    time_stamp_out = 16'h0000;
  end
  // free running stamp source
  always @(posedge clk_sys_in) begin
    time_stamp_out <= time_stamp_out + 16'h0001;
  end
  // end of frame strobe comes one cycle after the last byte
  task automatic send(input logic [31:0] id, input logic [7:0] d, input logic ok,
                      input logic own);
    logic [7:0] b;
    for (int i = 0; i < 13; i++) begin
      b = (i < ID_BYTES) ? id[31-8*i -: 8] : d;
      @(posedge clk_sys_in);
      frame_end_out <= 1'b0;
      frame_own_out <= own;
      frame_byte_valid_out <= 1'b1;
      frame_byte_idx_out <= i[IDX_W-1:0];
      frame_byte_out <= b;
    end
    @(posedge clk_sys_in);
    frame_byte_valid_out <= 1'b0;
    // released data line never repeats the last byte
    frame_byte_out <= ~b;
    frame_end_out <= 1'b1;
    frame_ok_out <= ok;
  endtask
  task automatic idle();
    @(posedge clk_sys_in);
    frame_end_out <= 1'b0;
    frame_ok_out <= ~frame_ok_out;
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the receive queue and acceptance filter
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  import crff_pkg::*;
  logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, frame_byte_in;
  logic frame_byte_valid_in, frame_end_in, frame_ok_in, frame_own_in;
  logic [IDX_W-1:0] frame_byte_idx_in;
  logic [TS_W-1:0] time_stamp_in;
  logic ack_enable_out, rx_full_out, rx_irq_out, overrun_irq_out;
  int n_errors = 0;
  int n_compared = 0;
  crff_mode_t cur_mode;
  logic loop;
  logic [7:0] v;

  crff_top u_crff_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .frame_byte_valid_in(frame_byte_valid_in), .frame_byte_idx_in(frame_byte_idx_in),
    .frame_byte_in(frame_byte_in), .frame_end_in(frame_end_in), .frame_ok_in(frame_ok_in),
    .frame_own_in(frame_own_in), .time_stamp_in(time_stamp_in),
    .ack_enable_out(ack_enable_out), .rx_full_out(rx_full_out), .rx_irq_out(rx_irq_out),
    .overrun_irq_out(overrun_irq_out));
  crff_frame_src u_crff_frame_src (.clk_sys_in(clk_sys_in),
    .frame_byte_valid_out(frame_byte_valid_in), .frame_byte_idx_out(frame_byte_idx_in),
    .frame_byte_out(frame_byte_in), .frame_end_out(frame_end_in),
    .frame_ok_out(frame_ok_in), .frame_own_out(frame_own_in),
    .time_stamp_out(time_stamp_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_wdata_in <= ~d;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask
  // filter setup is written only with init set, then the controller goes on line
  task automatic cfg(input crff_mode_t m, input logic [63:0] fv, input logic [63:0] fm,
                     input logic [7:0] c);
    wr(OFF_CTRL, CTRL_RST);
    wr(OFF_ACC_CTRL, {2'b00, m, 4'h0});
    for (int i = 0; i < FILT_REGS; i++) begin
      wr(OFF_VAL_BASE + i[ADDR_W-1:0], fv[63-8*i -: 8]);
      wr(OFF_MSK_BASE + i[ADDR_W-1:0], fm[63-8*i -: 8]);
    end
    wr(OFF_CTRL, c);
    rd(OFF_ACC_CTRL, v);
    `CHK(v & 8'h30, {2'b00, m, 4'h0})
    cur_mode = m;
    loop = c[CTRL_LOOP_BIT];
  endtask
  // one frame; an accepted one is read from the head window and released
  task automatic frame(input logic [31:0] id, input logic [7:0] d, input logic ok,
                       input logic own, input logic acc, input logic [2:0] hit);
    u_crff_frame_src.send(id, d, ok, own);
    u_crff_frame_src.idle();
    #1;
    `CHK(ack_enable_out, ~own | loop)
    `CHK(rx_full_out, acc)
    `CHK(rx_irq_out, acc)
    rd(OFF_HEAD_BASE, v);
    `CHK(v, acc ? id[31:24] : BYTE_ZERO)
    if (acc) begin
      rd(OFF_HEAD_BASE + 6'h04, v);
      `CHK(v, d)
      rd(OFF_ACC_CTRL, v);
      `CHK(v & 8'h37, {2'b00, cur_mode, 1'b0, hit})
      wr(OFF_FLAG, 8'h01);
      `CHK(rx_full_out, 1'b0)
    end
  endtask

  task automatic t_reset();
    `CHK(ack_enable_out, 1'b1)
    `CHK(rx_full_out | rx_irq_out | overrun_irq_out, 1'b0)
    rd(OFF_CTRL, v);
    `CHK(v, CTRL_RST)
    rd(OFF_IRQEN, v);
    `CHK(v, IRQEN_RST)
    rd(OFF_MSK_BASE, v);
    `CHK(v, FILT_RST)
    rd(6'h3F, v);
    `CHK(v, BYTE_ZERO)
    wr(OFF_IRQEN, 8'h03);
  endtask
  task automatic t_modes();
    cfg(CRFF_MODE_32, 64'h11223344_55667788, 64'h000000FF_00000000, 8'h00);
    frame(32'h11223399, 8'h5A, 1'b1, 1'b0, 1'b1, 3'd0);
    frame(32'h55667788, 8'hA5, 1'b1, 1'b0, 1'b1, 3'd1);
    frame(32'h11AA3344, 8'h01, 1'b1, 1'b0, 1'b0, 3'd0);
    frame(32'h11223344, 8'h02, 1'b0, 1'b0, 1'b0, 3'd0);
    // standard identifiers are filtered with the narrow modes
    cfg(CRFF_MODE_16, 64'h12345678_9ABCDEF0, 64'h0, 8'h00);
    frame(32'h9ABC0000, 8'h03, 1'b1, 1'b0, 1'b1, 3'd2);
    frame(32'hDEF01111, 8'h04, 1'b1, 1'b0, 1'b1, 3'd3);
    frame(32'h56780000, 8'h05, 1'b1, 1'b0, 1'b1, 3'd1);
    frame(32'h12350000, 8'h06, 1'b1, 1'b0, 1'b0, 3'd0);
    cfg(CRFF_MODE_8, 64'hA0A1C5A3_A4C5A6A7, 64'h00000000_000000FF, 8'h00);
    frame(32'hC5000000, 8'h07, 1'b1, 1'b0, 1'b1, 3'd2);
    frame(32'hA4FFFFFF, 8'h08, 1'b1, 1'b0, 1'b1, 3'd4);
    frame(32'h01000000, 8'h09, 1'b1, 1'b0, 1'b1, 3'd7);
    cfg(CRFF_MODE_CLOSED, 64'h0, 64'hFFFFFFFF_FFFFFFFF, 8'h00);
    frame(32'hA0000000, 8'h0A, 1'b1, 1'b0, 1'b0, 3'd0);
  endtask
  task automatic t_own_lock();
    cfg(CRFF_MODE_8, 64'hA0A1A2A3_A4A5A6A7, 64'h0, 8'h00);
    frame(32'hA0000000, 8'h0B, 1'b1, 1'b1, 1'b0, 3'd0);
    wr(OFF_ACC_CTRL, 8'h30);
    wr(OFF_VAL_BASE, 8'h77);
    rd(OFF_VAL_BASE, v);
    `CHK(v, 8'hA0)
    frame(32'hA0000000, 8'h0C, 1'b1, 1'b0, 1'b1, 3'd0);
    frame(32'h77000000, 8'h0D, 1'b1, 1'b0, 1'b0, 3'd0);
    cfg(CRFF_MODE_8, 64'hA0A1A2A3_A4A5A6A7, 64'h0, 8'h02);
    frame(32'hA3000000, 8'h0E, 1'b1, 1'b1, 1'b1, 3'd3);
  endtask
  task automatic t_overrun();
    cfg(CRFF_MODE_8, 64'h0, 64'hFFFFFFFF_FFFFFFFF, 8'h00);
    for (int k = 0; k < RX_DEPTH + 1; k++) begin
      u_crff_frame_src.send(32'hA0000000, k[7:0], 1'b1, 1'b0);
    end
    u_crff_frame_src.idle();
    #1;
    `CHK(overrun_irq_out, 1'b1)
    rd(OFF_FLAG, v);
    `CHK(v, 8'h03)
    wr(OFF_IRQEN, 8'h02);
    @(posedge clk_sys_in);
    #1;
    `CHK({rx_full_out, rx_irq_out}, 2'b10)
    wr(OFF_IRQEN, 8'h03);
    wr(OFF_FLAG, 8'h01);
    u_crff_frame_src.send(32'hA0000000, 8'h07, 1'b1, 1'b0);
    u_crff_frame_src.idle();
    for (int k = 1; k < RX_DEPTH + 1; k++) begin
      rd(OFF_HEAD_BASE + 6'h04, v);
      `CHK(v, (k == RX_DEPTH) ? 8'h07 : k[7:0])
      `CHK(rx_full_out, 1'b1)
      wr(OFF_FLAG, 8'h01);
    end
    `CHK(rx_full_out, 1'b0)
    wr(OFF_FLAG, 8'h02);
    @(posedge clk_sys_in);
    #1;
    `CHK(overrun_irq_out, 1'b0)
  endtask
  // stamp enabled: last two head bytes carry the stamp taken at frame end
  task automatic t_stamp();
    logic [TS_W-1:0] ts;
    cfg(CRFF_MODE_8, 64'h0, 64'hFFFFFFFF_FFFFFFFF, 8'h04);
    u_crff_frame_src.send(32'hA0000000, 8'h21, 1'b1, 1'b0);
    u_crff_frame_src.idle();
    #1;
    ts = time_stamp_in - 16'h0001;
    rd(OFF_HEAD_BASE + 6'h0C, v);
    `CHK(v, 8'h21)
    rd(OFF_HEAD_BASE + 6'h0D, v);
    `CHK(v, ts[15:8])
    rd(OFF_HEAD_BASE + 6'h0E, v);
    `CHK(v, ts[7:0])
    @(posedge clk_sys_in);
    #1;
    `CHK(reg_rdata_out, BYTE_ZERO)
    wr(OFF_FLAG, 8'h01);
    `CHK(rx_full_out, 1'b0)
  endtask

  initial begin
    rst_n_in = 1'b0;
    reg_addr_in = 6'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    loop = 1'b0;
    cur_mode = CRFF_MODE_32;
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    t_reset();
    t_modes();
    t_own_lock();
    t_overrun();
    t_stamp();
    results();
  end

  initial begin
    #(8 * 40000);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
